// ### src/rbc_pkg.sv
// Constants, types and layouts for the reset configuration decoder.
// Assumes a single 50 MHz clock domain; config switch ON reads as a low level.
package rbc_pkg;

  // Clock and serial timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int SPI_HALF_NS   = 80;
  localparam int SPI_HALF_CYC  = (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Boot source codes on the boot select pins
  localparam logic [1:0] BOOT_DEFAULT  = 2'h0;
  localparam logic [1:0] BOOT_RESERVED = 2'h1;
  localparam logic [1:0] BOOT_PARALLEL = 2'h2;
  localparam logic [1:0] BOOT_SERIAL   = 2'h3;

  // Config switch electrical level for ON
  localparam logic SW_ON = 1'b0;

  // Field positions in the raw byte (config bit n sits at index n-1)
  localparam int MODE_MSB  = 7;
  localparam int MODE_LSB  = 5;
  localparam int LIMP_POS  = 4;
  localparam int HOST_POS  = 3;
  localparam int SLEW_POS  = 2;
  localparam int MULT3_MSB = 2;
  localparam int MULT2_MSB = 1;

  // Built-in defaults: PCI muxed 8-bit, PLL, host, 66 MHz slew, x6
  localparam logic [7:0] DEFAULT_RAW = 8'h12;

  // Serial read: command, start address, bit counts
  localparam logic [7:0]  SPI_READ_CMD = 8'h03;
  localparam logic [23:0] SPI_ADDR     = 24'h000000;
  localparam int          SPI_HDR_BITS = 32;
  localparam int          SPI_DAT_BITS = 8;

  typedef enum logic [1:0] {
    RBC_PS_8  = 2'b00,
    RBC_PS_16 = 2'b01,
    RBC_PS_32 = 2'b10
  } rbc_port_size_t;

  typedef enum logic [2:0] {
    RBC_IDLE = 3'b000,
    RBC_HOLD = 3'b001,
    RBC_SHDR = 3'b010,
    RBC_SDAT = 3'b011,
    RBC_DONE = 3'b100
  } rbc_state_t;

  typedef struct packed {
    logic           pci_en;
    logic           muxed;
    rbc_port_size_t port_size;
    logic           limp;
    logic           pci_host;
    logic           osc_bypass;
    logic           slew_66;
    logic [4:0]     pll_mult;
  } rbc_cfg_t;

  // Serial boot pins toward the external memory
  typedef struct packed {
    logic clk;
    logic cs_n;
    logic dout;
  } rbc_spi_out_t;

endpackage : rbc_pkg

// ### src/reset_boot_config_decoder.sv
// Reset configuration capture and decode for the processor.
// Assumes reset_output_n comes from logic on the same clock and that the
// boot select pins, the low address/data lines and serial data in are pins.
`timescale 1ns/1ps
module reset_boot_config_decoder
  import rbc_pkg::*;
#(
  parameter int HALF_CYC = SPI_HALF_CYC
) (
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           rst,
  // Device reset output, low while asserted
  input  wire logic           reset_output_n,
  // Strap pins
  input  wire logic [1:0]     boot_select_pins,
  input  wire logic [7:0]     local_bus_addr_data,
  // Serial boot memory
  input  wire logic           serial_boot_data_in,
  output rbc_pkg::rbc_spi_out_t spi_o,
  // Decoded configuration
  output rbc_pkg::rbc_cfg_t   cfg,
  output logic [1:0]          cfg_source,
  output logic                cfg_valid,
  output logic                serial_busy
);
  import rbc_pkg::*;

  localparam int TOTAL_BITS = SPI_HDR_BITS + SPI_DAT_BITS;
  localparam logic [31:0] HDR_WORD = {SPI_READ_CMD, SPI_ADDR};

  // Pin synchronisers, three stages
  logic [1:0]  boot_s1_q, boot_s2_q, boot_s3_q, boot_q;
  logic [7:0]  ad_s1_q, ad_s2_q, ad_s3_q, ad_q;
  logic        di_s1_q, di_s2_q, di_s3_q, di_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      boot_s1_q <= 2'h0;
      boot_s2_q <= 2'h0;
      boot_s3_q <= 2'h0;
      boot_q    <= 2'h0;
    end else begin
      boot_s1_q <= boot_select_pins;
      boot_s2_q <= boot_s1_q;
      boot_s3_q <= boot_s2_q;
      if (boot_s2_q == boot_s3_q) begin
        boot_q <= boot_s3_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ad_s1_q <= 8'h00;
      ad_s2_q <= 8'h00;
      ad_s3_q <= 8'h00;
      ad_q    <= 8'h00;
    end else begin
      ad_s1_q <= local_bus_addr_data;
      ad_s2_q <= ad_s1_q;
      ad_s3_q <= ad_s2_q;
      if (ad_s2_q == ad_s3_q) begin
        ad_q <= ad_s3_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      di_s1_q <= 1'b0;
      di_s2_q <= 1'b0;
      di_s3_q <= 1'b0;
      di_q    <= 1'b0;
    end else begin
      di_s1_q <= serial_boot_data_in;
      di_s2_q <= di_s1_q;
      di_s3_q <= di_s2_q;
      if (di_s2_q == di_s3_q) begin
        di_q <= di_s3_q;
      end
    end
  end

  // Release edge of reset output
  logic rso_q;
  logic rso_rise;

  always_ff @(posedge clock) begin
    if (rst) begin
      rso_q <= 1'b0;
    end else begin
      rso_q <= reset_output_n;
    end
  end

  assign rso_rise = reset_output_n && !rso_q;

  // Sequencer
  rbc_state_t  state_q;
  logic [5:0]  bit_q;
  logic [7:0]  div_q;
  logic [7:0]  raw_q;
  logic [1:0]  src_q;
  logic        div_end;
  logic        div_start;

  assign div_end   = (div_q == 8'(2 * HALF_CYC - 1));
  assign div_start = (div_q == 8'h00);

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= RBC_IDLE;
      src_q   <= BOOT_DEFAULT;
    end else begin
      case (state_q)
        RBC_IDLE, RBC_DONE: begin
          if (!reset_output_n) begin
            state_q <= RBC_HOLD;
          end
        end
        RBC_HOLD: begin
          if (rso_rise) begin
            src_q <= boot_q;
            if (boot_q == BOOT_SERIAL) begin
              state_q <= RBC_SHDR;
            end else begin
              state_q <= RBC_DONE;
            end
          end
        end
        RBC_SHDR: begin
          if (div_end && bit_q == 6'(SPI_HDR_BITS - 1)) begin
            state_q <= RBC_SDAT;
          end
        end
        RBC_SDAT: begin
          if (div_end && bit_q == 6'(TOTAL_BITS - 1)) begin
            state_q <= RBC_DONE;
          end
        end
        default: begin
          state_q <= RBC_IDLE;
        end
      endcase
    end
  end

  // Serial clock divider and bit counter
  always_ff @(posedge clock) begin
    if (rst) begin
      div_q <= 8'h00;
      bit_q <= 6'h00;
    end else if (state_q == RBC_SHDR || state_q == RBC_SDAT) begin
      div_q <= div_end ? 8'h00 : div_q + 8'h01;
      if (div_end) begin
        bit_q <= bit_q + 6'h01;
      end
    end else begin
      div_q <= 8'h00;
      bit_q <= 6'h00;
    end
  end

  // Serial pins; data changes while the clock is low, memory sampled at end of high
  logic spi_clk_q, spi_cs_n_q, spi_do_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      spi_clk_q  <= 1'b0;
      spi_cs_n_q <= 1'b1;
      spi_do_q   <= 1'b0;
    end else if (state_q == RBC_SHDR || state_q == RBC_SDAT) begin
      spi_cs_n_q <= 1'b0;
      spi_clk_q  <= (div_q >= 8'(HALF_CYC - 1)) && !div_end;
      if (div_start) begin
        if (state_q == RBC_SHDR) begin
          spi_do_q <= HDR_WORD[5'(SPI_HDR_BITS - 1) - bit_q[4:0]];
        end else begin
          spi_do_q <= 1'b0;
        end
      end
    end else begin
      spi_clk_q  <= 1'b0;
      spi_cs_n_q <= 1'b1;
      spi_do_q   <= 1'b0;
    end
  end

  // Raw configuration byte
  always_ff @(posedge clock) begin
    if (rst) begin
      raw_q <= DEFAULT_RAW;
    end else if (state_q == RBC_HOLD && rso_rise) begin
      if (boot_q == BOOT_PARALLEL) begin
        raw_q <= ad_q;
      end else if (boot_q != BOOT_SERIAL) begin
        raw_q <= DEFAULT_RAW;
      end
    end else if (state_q == RBC_SDAT && div_end) begin
      // Bit 8 first; outputs track every arriving bit
      raw_q <= {raw_q[6:0], di_q};
    end
    // Otherwise held across the whole following run
  end

  // Decode
  function automatic rbc_cfg_t decode(input logic [7:0] raw);
    logic [2:0] m;
    logic [2:0] k3;
    logic [1:0] k2;
    rbc_cfg_t   c;
    m  = {raw[MODE_MSB] ^ SW_ON, raw[MODE_MSB-1] ^ SW_ON, raw[MODE_LSB] ^ SW_ON};
    k3 = {raw[MULT3_MSB] ^ SW_ON, raw[MULT3_MSB-1] ^ SW_ON, raw[MULT3_MSB-2] ^ SW_ON};
    k2 = {raw[MULT2_MSB] ^ SW_ON, raw[MULT2_MSB-1] ^ SW_ON};
    c  = '0;
    case (m)
      3'h0: begin c.pci_en = 1'b1; c.muxed = 1'b1; c.port_size = RBC_PS_8;  end
      3'h1: begin c.pci_en = 1'b0; c.muxed = 1'b1; c.port_size = RBC_PS_16; end
      3'h2: begin c.pci_en = 1'b0; c.muxed = 1'b1; c.port_size = RBC_PS_8;  end
      3'h3: begin c.pci_en = 1'b0; c.muxed = 1'b1; c.port_size = RBC_PS_32; end
      3'h4: begin c.pci_en = 1'b1; c.muxed = 1'b1; c.port_size = RBC_PS_16; end
      3'h5: begin c.pci_en = 1'b0; c.muxed = 1'b0; c.port_size = RBC_PS_16; end
      3'h6: begin c.pci_en = 1'b0; c.muxed = 1'b0; c.port_size = RBC_PS_8;  end
      default: begin c.pci_en = 1'b0; c.muxed = 1'b0; c.port_size = RBC_PS_32; end
    endcase
    c.limp = (raw[LIMP_POS] == SW_ON);
    if (c.pci_en) begin
      c.pci_host = (raw[HOST_POS] == SW_ON);
      c.slew_66  = (raw[SLEW_POS] == SW_ON);
      case (k2)
        2'h0:    c.pll_mult = 5'h08;
        2'h1:    c.pll_mult = 5'h10;
        2'h2:    c.pll_mult = 5'h06;
        default: c.pll_mult = 5'h0C;
      endcase
    end else begin
      c.osc_bypass = (raw[HOST_POS] == SW_ON);
      case (k3)
        3'h0:    c.pll_mult = 5'h08;
        3'h1:    c.pll_mult = 5'h10;
        3'h2:    c.pll_mult = 5'h06;
        3'h3:    c.pll_mult = 5'h0C;
        3'h4:    c.pll_mult = 5'h12;
        3'h5:    c.pll_mult = 5'h18;
        3'h6:    c.pll_mult = 5'h0A;
        default: c.pll_mult = 5'h14;
      endcase
    end
    return c;
  endfunction : decode

  // Registered outputs; serial_busy is decoded from state_q
  rbc_cfg_t cfg_q;
  logic     valid_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_q   <= decode(DEFAULT_RAW);
      valid_q <= 1'b0;
    end else begin
      cfg_q   <= decode(raw_q);
      valid_q <= (state_q == RBC_DONE);
    end
  end

  assign cfg         = cfg_q;
  assign cfg_source  = src_q;
  assign cfg_valid   = valid_q;
  assign serial_busy = (state_q == RBC_SHDR) || (state_q == RBC_SDAT);
  assign spi_o.clk   = spi_clk_q;
  assign spi_o.cs_n  = spi_cs_n_q;
  assign spi_o.dout  = spi_do_q;

endmodule : reset_boot_config_decoder

// ### verif/rbc_board_model.sv
// Board side: strap switch buffer and serial configuration memory.
// Assumes the memory answers in clock mode 0, MSB first.
`timescale 1ns/1ps
module rbc_board_model (
  // Switches and stored byte
  input  wire logic [1:0]            mode_switch_pair,
  input  wire logic [7:0]            config_switch_bank,
  input  wire logic [7:0]            stored_byte,
  // Device side
  input  wire logic                  reset_output_n,
  input  wire rbc_pkg::rbc_spi_out_t spi_o,
  output logic [1:0]                 boot_select_pins,
  output logic [7:0]                 local_bus_addr_data,
  output logic                       serial_boot_data_in
);
  import rbc_pkg::*;
  logic [7:0]  last_q;
  logic [31:0] hdr;
  int          cnt;
  initial serial_boot_data_in = 1'b0;
  // Pair reads 1 for OFF
  assign boot_select_pins = mode_switch_pair;
  always_latch begin
    if (!reset_output_n) last_q <= config_switch_bank;
  end
  // Released lines have no pull; show the inverse instead
  assign local_bus_addr_data = reset_output_n ? ~last_q : config_switch_bank;
  always @(negedge spi_o.cs_n) begin
    cnt = 0;
    hdr = '0;
  end
  always @(posedge spi_o.clk) begin
    if (!spi_o.cs_n && cnt < 32) hdr = {hdr[30:0], spi_o.dout};
    cnt = cnt + 1;
  end
  always @(negedge spi_o.clk or posedge spi_o.cs_n) begin
    if (!spi_o.cs_n && cnt >= 32 && cnt < 40 && hdr == {SPI_READ_CMD, SPI_ADDR}) begin
      serial_boot_data_in = stored_byte[39-cnt];
    end else begin
      serial_boot_data_in = ~serial_boot_data_in;
    end
  end
endmodule : rbc_board_model

// ### verif/rbc_checker_assertions.sv
// Port checker for the reset configuration decoder.
// Assumes one clock domain and a synchronous active-high rst.
`timescale 1ns/1ps
module rbc_checker (
  // Clock, reset and strobe
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  reset_output_n,
  // Outputs of the decoder
  input wire rbc_pkg::rbc_spi_out_t spi_o,
  input wire rbc_pkg::rbc_cfg_t     cfg,
  input wire logic [1:0]            cfg_source,
  input wire logic                  cfg_valid,
  input wire logic                  serial_busy
);
  import rbc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_pci_bus; cfg.pci_en |-> cfg.muxed && cfg.port_size != RBC_PS_32; endproperty
  a_pci_bus: assert property (p_pci_bus) else $error("pci bus mode");
  property p_pci_only; !cfg.pci_en |-> !cfg.pci_host && !cfg.slew_66; endproperty
  a_pci_only: assert property (p_pci_only) else $error("pci field outside pci");
  property p_osc; cfg.pci_en |-> !cfg.osc_bypass; endproperty
  a_osc: assert property (p_osc) else $error("oscillator field in pci");
  property p_mult_pci; cfg.pci_en |-> cfg.pll_mult inside {5'h8, 5'h10, 5'h6, 5'hC}; endproperty
  a_mult_pci: assert property (p_mult_pci) else $error("pci multiplier");
  property p_mult_np;
    !cfg.pci_en |-> cfg.pll_mult inside {5'h8, 5'h10, 5'h6, 5'hC, 5'h12, 5'h18, 5'hA, 5'h14};
  endproperty
  a_mult_np: assert property (p_mult_np) else $error("multiplier");
  property p_src_edge; $changed(cfg_source) |-> $past(reset_output_n) && !$past(reset_output_n, 2);
  endproperty
  a_src_edge: assert property (p_src_edge) else $error("source moved off edge");
  property p_stable; cfg_valid && $past(cfg_valid) |-> $stable(cfg) && $stable(cfg_source);
  endproperty
  a_stable: assert property (p_stable) else $error("config moved");
  property p_drop; $fell(reset_output_n) && !serial_busy |-> ##[1:2] !cfg_valid; endproperty
  a_drop: assert property (p_drop) else $error("valid held in reset");
  property p_busy_src; serial_busy |-> cfg_source == BOOT_SERIAL; endproperty
  a_busy_src: assert property (p_busy_src) else $error("serial read wrong source");
  property p_frame; spi_o.clk |-> !spi_o.cs_n; endproperty
  a_frame: assert property (p_frame) else $error("serial clock outside frame");
  property p_idle; !serial_busy && !$past(serial_busy) |-> spi_o.cs_n && !spi_o.clk; endproperty
  a_idle: assert property (p_idle) else $error("serial pins not idle");
  c_par: cover property ($rose(cfg_valid) && cfg_source == BOOT_PARALLEL);
  c_ser: cover property ($rose(cfg_valid) && cfg_source == BOOT_SERIAL);
  c_def: cover property ($rose(cfg_valid) && cfg_source == BOOT_DEFAULT);
endmodule : rbc_checker

bind reset_boot_config_decoder rbc_checker rbc_checker_inst (.clock(clock), .rst(rst),
  .reset_output_n(reset_output_n), .spi_o(spi_o), .cfg(cfg), .cfg_source(cfg_source),
  .cfg_valid(cfg_valid), .serial_busy(serial_busy));

// ### verif/testbench.sv
// Self-checking bench for the reset configuration decoder.
// Assumes the board model answers for the switches and serial memory.
`timescale 1ns/1ps
module testbench;
  import rbc_pkg::*;
  localparam logic [4:0] MULT [8] = '{5'h8, 5'h10, 5'h6, 5'hC, 5'h12, 5'h18, 5'hA, 5'h14};
  logic         clock, rst, reset_output_n, serial_boot_data_in, cfg_valid, serial_busy;
  logic [1:0]   mode_switch_pair, boot_select_pins, cfg_source;
  logic [7:0]   config_switch_bank, stored_byte, local_bus_addr_data;
  rbc_spi_out_t spi_o;
  rbc_cfg_t     cfg;
  int           err_total, check_count;

  reset_boot_config_decoder reset_boot_config_decoder_inst (.clock(clock), .rst(rst),
    .reset_output_n(reset_output_n), .boot_select_pins(boot_select_pins),
    .local_bus_addr_data(local_bus_addr_data), .serial_boot_data_in(serial_boot_data_in),
    .spi_o(spi_o), .cfg(cfg), .cfg_source(cfg_source), .cfg_valid(cfg_valid),
    .serial_busy(serial_busy));
  rbc_board_model rbc_board_model_inst (.mode_switch_pair(mode_switch_pair),
    .config_switch_bank(config_switch_bank), .stored_byte(stored_byte),
    .reset_output_n(reset_output_n), .spi_o(spi_o), .boot_select_pins(boot_select_pins),
    .local_bus_addr_data(local_bus_addr_data), .serial_boot_data_in(serial_boot_data_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Switch ON reads 0
  function automatic rbc_cfg_t decode(logic [7:0] r);
    rbc_cfg_t c;
    c = '0;
    c.pci_en = r[6:5] == 2'h0;
    c.muxed = !r[7] || c.pci_en;
    c.port_size = r[6:5] == 2'h3 ? RBC_PS_32 :
                  (r[6:5] == 2'h1 || r[7:5] == 3'h4) ? RBC_PS_16 : RBC_PS_8;
    c.limp = !r[4];
    c.pci_host = c.pci_en && !r[3];
    c.osc_bypass = !c.pci_en && !r[3];
    c.slew_66 = c.pci_en && !r[2];
    c.pll_mult = MULT[c.pci_en ? {1'b0, r[1:0]} : r[2:0]];
    return c;
  endfunction : decode

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // One reset sequence, then the result and its hold after release
  task automatic judge(logic [1:0] pair, logic [7:0] sw, logic [7:0] mem, logic [7:0] raw);
    int n;
    @(negedge clock);
    mode_switch_pair = pair;
    config_switch_bank = sw;
    stored_byte = mem;
    reset_output_n = 1'b0;
    repeat (10) @(negedge clock);
    reset_output_n = 1'b1;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    if (cfg_valid !== 1'b1) begin
      err_total++;
      end_sim();
    end
    chk("cfg", {3'h0, cfg}, {3'h0, decode(raw)});
    chk("source", {14'h0, cfg_source}, {14'h0, pair});
    mode_switch_pair = ~pair;
    config_switch_bank = ~sw;
    repeat (20) @(negedge clock);
    chk("held cfg", {3'h0, cfg}, {3'h0, decode(raw)});
    chk("held source", {14'h0, cfg_source}, {14'h0, pair});
  endtask : judge

  task automatic test_reset;
    chk("reset cfg", {3'h0, cfg}, {3'h0, decode(DEFAULT_RAW)});
    chk("reset valid", {15'h0, cfg_valid}, 16'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_parallel;
    logic [4:0] i;
    for (int k = 0; k < 32; k++) begin
      i = 5'(k);
      judge(BOOT_PARALLEL, {i[2:0], i[3], i[4], i[4:2]}, 8'h5A, {i[2:0], i[3], i[4], i[4:2]});
    end
    // Flash boot straps: PCI, muxed, 8-bit
    judge(BOOT_PARALLEL, 8'h12, 8'h00, 8'h12);
    $display("test parallel done");
  endtask : test_parallel

  task automatic test_default;
    judge(BOOT_DEFAULT, 8'hE7, 8'h00, DEFAULT_RAW);
    judge(BOOT_RESERVED, 8'h6C, 8'h00, DEFAULT_RAW);
    $display("test default done");
  endtask : test_default

  task automatic test_serial;
    judge(BOOT_SERIAL, 8'h00, 8'hB6, 8'hB6);
    judge(BOOT_SERIAL, 8'hFF, 8'h49, 8'h49);
    $display("test serial done");
  endtask : test_serial

  initial begin
    rst = 1'b1;
    reset_output_n = 1'b1;
    mode_switch_pair = 2'h0;
    config_switch_bank = 8'h00;
    stored_byte = 8'h00;
    err_total = 0;
    check_count = 0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    test_reset();
    test_parallel();
    test_default();
    test_serial();
    end_sim();
  end
endmodule : testbench
